// ---- design/stcr_cfg.svh ----
// Purpose: Timing counts and fixed bus values for the tone code bus master
// Assumes: 50 MHz system clock
// Notes:   Counts round up so that every phase meets its least time
`ifndef STCR_CFG_SVH
`define STCR_CFG_SVH

// ==================================================================
// Clock and phase times
`define STCR_CLK_NS       20
`define STCR_CYC(ns)      (((ns) + `STCR_CLK_NS - 1) / `STCR_CLK_NS)
`define STCR_STD_LOW_NS   4700
`define STCR_STD_HIGH_NS  4000
`define STCR_SLOW_LOW_NS  130000
`define STCR_SLOW_HIGH_NS 390000
`define STCR_STD_LOW_CYC  `STCR_CYC(`STCR_STD_LOW_NS)
`define STCR_STD_HIGH_CYC `STCR_CYC(`STCR_STD_HIGH_NS)
`define STCR_SLOW_LOW_CYC `STCR_CYC(`STCR_SLOW_LOW_NS)
`define STCR_SLOW_HI_CYC  `STCR_CYC(`STCR_SLOW_HIGH_NS)

// ==================================================================
// Bus bytes and field values
`define STCR_START_BYTE   8'h01
`define STCR_RW_WRITE     1'h0
`define STCR_ADDR_HIGH    6'h24
`define STCR_ACK_BIT      4'h8
`define STCR_IDX_START    2'h0
`define STCR_IDX_ADDR     2'h1
`define STCR_IDX_DATA     2'h2

`endif

// ---- design/stcr_pkg.sv ----
// Purpose: Types of the tone code bus master
// Assumes: Nothing beyond the header of constants
// Notes:   Reset values are applied in the modules
package stcr_pkg;

	// ==================================================================
	// Bus phase of the master
	typedef enum logic [3:0] {
		ST_IDLE   = 4'h0, // Bus idle, ready for a command
		ST_START  = 4'h1, // SDA low, SCL high: start hold
		ST_BLOW   = 4'h2, // Bit clock low, data placed
		ST_BHIGH  = 4'h3, // Bit clock high, data stable
		ST_RSLOW  = 4'h4, // Clock low before repeated start
		ST_RSHIGH = 4'h5, // Repeated start setup
		ST_PLOW   = 4'h6, // Clock low, SDA pulled before stop
		ST_PHIGH  = 4'h7, // Stop setup
		ST_FREE   = 4'h8  // Bus free time after stop
	} stcr_state_type;

	// ==================================================================
	// Whole state of the master
	typedef struct packed {
		stcr_state_type st;       // Bus phase
		logic [3:0]     bit_cnt;  // Bit within byte, 8 is ack
		logic [1:0]     byte_idx; // Start byte, address or data
		logic [7:0]     shreg;    // Outgoing byte, MSB first
		logic [5:0]     code;     // Tone code of the command
		logic           slow;     // Low speed timing chosen
		logic           strap;    // Target address LSB
		logic           scl_oe_n; // Low while SCL is pulled
		logic           sda_oe_n; // Low while SDA is pulled
		logic           pin_lvl;  // Level driven on the pins
		logic           ld;       // Phase timer load pulse
		logic [15:0]    len;      // Phase length in cycles
		logic           rdy;      // Ready for a command
		logic           busy;     // Transfer under way
		logic           done;     // Transfer finished pulse
		logic           nack;     // Target did not acknowledge
		logic           scl_m;    // SCL first sync stage
		logic           scl_s;    // SCL synchronised
		logic           sda_m;    // SDA first sync stage
		logic           sda_s;    // SDA synchronised
	} stcr_main_type;

	// ==================================================================
	// Whole state of the phase timer
	typedef struct packed {
		logic [15:0] cnt;  // Cycles left in phase
		logic        tick; // Phase end pulse
	} stcr_timer_type;

endpackage : stcr_pkg

// ---- design/stcr_phase_timer.sv ----
// Purpose: Phase timer giving a one-cycle enable at the end of each bus phase
// Assumes: len is at least 1 when load is pulsed
// Notes:   tick comes len+1 cycles after the load pulse
module stcr_phase_timer
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Phase control
	input  wire logic        load,
	input  wire logic [15:0] len,
	// Phase end
	output logic             tick
);

	// ==================================================================
	// State
	stcr_pkg::stcr_timer_type t_ff;  // Registered state
	stcr_pkg::stcr_timer_type nxt_t; // Next state

	// Count down after a load, pulse at the last cycle
	always_comb
	begin
		nxt_t = t_ff;
		nxt_t.tick = !load && (t_ff.cnt == 16'h0001);
		if (load)
		begin
			nxt_t.cnt = len;
		end
		else if (t_ff.cnt != 16'h0000)
		begin
			nxt_t.cnt = t_ff.cnt - 16'h0001;
		end
	end

	// Register the state
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			t_ff <= '0;
		end
		else
		begin
			t_ff <= nxt_t;
		end
	end

	assign tick = t_ff.tick;

endmodule : stcr_phase_timer

// ---- design/stcr_master.sv ----
// Purpose: Bus master that sends one tone code to the serial tone receiver
// Assumes: Open-drain SCL and SDA with external pull-ups, no clock stretching
// Notes:   Each command is start, address, code byte, stop, with no code byte after a refused address; slow mode adds a start byte
`include "stcr_cfg.svh"
module stcr_master
#(
	parameter logic [15:0] SLOW_LOW_CYC  = 16'(`STCR_SLOW_LOW_CYC),
	parameter logic [15:0] SLOW_HIGH_CYC = 16'(`STCR_SLOW_HI_CYC),
	parameter logic [5:0]  ADDR_HIGH     = `STCR_ADDR_HIGH
)
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Command side
	input  wire logic       cmd_valid,
	input  wire logic [5:0] cmd_code,
	input  wire logic       cmd_slow,
	input  wire logic       address_strap_pin,
	output logic            cmd_ready,
	output logic            busy,
	output logic            done,
	output logic            nack,
	// Bus pins
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe_n,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n
);

	// ==================================================================
	// State and phase lengths
	localparam logic [15:0] STD_LOW_CYC  = 16'(`STCR_STD_LOW_CYC);
	localparam logic [15:0] STD_HIGH_CYC = 16'(`STCR_STD_HIGH_CYC);
	stcr_pkg::stcr_main_type s;     // Registered state
	stcr_pkg::stcr_main_type nxt_s; // Next state
	logic                    tick;  // Phase end enable
	logic [15:0]             lo_len; // Low phase length of the mode
	logic [15:0]             hi_len; // High phase length of the mode

	// Slow mode stretches both phases 1:3, the target needs no setting
	assign lo_len = s.slow ? SLOW_LOW_CYC : STD_LOW_CYC;
	assign hi_len = s.slow ? SLOW_HIGH_CYC : STD_HIGH_CYC;

	// ==================================================================
	// Phase timer
	stcr_phase_timer u_timer
	(
		.clk    (clk),
		.resetn (resetn),
		.load   (s.ld),
		.len    (s.len),
		.tick   (tick)
	);

	// ==================================================================
	// Next state
	always_comb
	begin
		nxt_s = s;
		nxt_s.ld = 1'b0;
		nxt_s.done = 1'b0;
		// Pin synchronisers
		nxt_s.scl_m = scl_in;
		nxt_s.scl_s = s.scl_m;
		nxt_s.sda_m = sda_in;
		nxt_s.sda_s = s.sda_m;
		unique case (s.st)
			stcr_pkg::ST_IDLE:
			begin
				// Accept only on an idle bus
				if (cmd_valid && s.rdy)
				begin
					nxt_s.code = cmd_code;
					nxt_s.slow = cmd_slow;
					nxt_s.strap = address_strap_pin;
					nxt_s.busy = 1'b1;
					nxt_s.nack = 1'b0;
					nxt_s.bit_cnt = 4'h0;
					nxt_s.st = stcr_pkg::ST_START;
					// Slow mode leads with the start byte
					if (cmd_slow)
					begin
						nxt_s.byte_idx = `STCR_IDX_START;
						nxt_s.shreg = `STCR_START_BYTE;
					end
					else
					begin
						nxt_s.byte_idx = `STCR_IDX_ADDR;
						nxt_s.shreg = {ADDR_HIGH, address_strap_pin, `STCR_RW_WRITE};
					end
				end
			end
			stcr_pkg::ST_START:
			begin
				// Start held for a clock high time
				if (tick && !s.ld) nxt_s.st = stcr_pkg::ST_BLOW;
			end
			stcr_pkg::ST_BLOW:
			begin
				if (tick && !s.ld) nxt_s.st = stcr_pkg::ST_BHIGH;
			end
			stcr_pkg::ST_BHIGH:
			begin
				if (tick && !s.ld)
				begin
					if (s.bit_cnt != `STCR_ACK_BIT)
					begin
						// Next data bit
						nxt_s.bit_cnt = s.bit_cnt + 4'h1;
						nxt_s.shreg = {s.shreg[6:0], 1'b0};
						nxt_s.st = stcr_pkg::ST_BLOW;
					end
					else if (s.byte_idx == `STCR_IDX_START)
					begin
						// Start byte ack is a dummy, then repeated start
						nxt_s.byte_idx = `STCR_IDX_ADDR;
						nxt_s.bit_cnt = 4'h0;
						nxt_s.shreg = {ADDR_HIGH, s.strap, `STCR_RW_WRITE};
						nxt_s.st = stcr_pkg::ST_RSLOW;
					end
					else if (s.byte_idx == `STCR_IDX_ADDR && !s.sda_s)
					begin
						// Address taken, send the code with top bits clear
						nxt_s.byte_idx = `STCR_IDX_DATA;
						nxt_s.bit_cnt = 4'h0;
						nxt_s.shreg = {2'h0, s.code};
						nxt_s.st = stcr_pkg::ST_BLOW;
					end
					else
					begin
						// Last byte or refused address: stop, never inside a byte
						nxt_s.nack = s.sda_s;
						nxt_s.st = stcr_pkg::ST_PLOW;
					end
				end
			end
			stcr_pkg::ST_RSLOW:
			begin
				if (tick && !s.ld) nxt_s.st = stcr_pkg::ST_RSHIGH;
			end
			stcr_pkg::ST_RSHIGH:
			begin
				if (tick && !s.ld) nxt_s.st = stcr_pkg::ST_START;
			end
			stcr_pkg::ST_PLOW:
			begin
				if (tick && !s.ld) nxt_s.st = stcr_pkg::ST_PHIGH;
			end
			stcr_pkg::ST_PHIGH:
			begin
				if (tick && !s.ld) nxt_s.st = stcr_pkg::ST_FREE;
			end
			stcr_pkg::ST_FREE:
			begin
				// Bus free time done, report
				if (tick && !s.ld)
				begin
					nxt_s.st = stcr_pkg::ST_IDLE;
					nxt_s.busy = 1'b0;
					nxt_s.done = 1'b1;
				end
			end
			default:
			begin
				nxt_s.st = stcr_pkg::ST_IDLE;
			end
		endcase
		// Start the timer on every phase change; setup, stop and free use low time
		if (nxt_s.st != s.st)
		begin
			nxt_s.ld = 1'b1;
			nxt_s.len = (nxt_s.st == stcr_pkg::ST_START || nxt_s.st == stcr_pkg::ST_BHIGH)
				? (nxt_s.slow ? SLOW_HIGH_CYC : STD_HIGH_CYC)
				: (nxt_s.slow ? SLOW_LOW_CYC : STD_LOW_CYC);
		end
		// SCL pulled only in low phases
		nxt_s.scl_oe_n = !(nxt_s.st == stcr_pkg::ST_BLOW || nxt_s.st == stcr_pkg::ST_RSLOW
			|| nxt_s.st == stcr_pkg::ST_PLOW);
		// SDA per phase; it changes only while SCL is low or as start and stop
		case (nxt_s.st)
			stcr_pkg::ST_BLOW:
			begin
				// SDA waits a cycle after SCL falls, so no edge reads as start or stop
				if (s.st != stcr_pkg::ST_BLOW)
				begin
					nxt_s.sda_oe_n = s.sda_oe_n;
				end
				else
				begin
					// Release for ack, else MSB of the byte
					nxt_s.sda_oe_n = (nxt_s.bit_cnt == `STCR_ACK_BIT) ? 1'b1 : nxt_s.shreg[7];
				end
			end
			stcr_pkg::ST_BHIGH: nxt_s.sda_oe_n = s.sda_oe_n;
			stcr_pkg::ST_START: nxt_s.sda_oe_n = 1'b0;
			stcr_pkg::ST_PLOW:
			begin
				// Pull SDA for the stop a cycle after SCL falls
				nxt_s.sda_oe_n = (s.st == stcr_pkg::ST_PLOW) ? 1'b0 : s.sda_oe_n;
			end
			stcr_pkg::ST_PHIGH: nxt_s.sda_oe_n = 1'b0;
			default:            nxt_s.sda_oe_n = 1'b1;
		endcase
		nxt_s.rdy = (nxt_s.st == stcr_pkg::ST_IDLE) && s.scl_s && s.sda_s;
	end

	// Register the state
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s <= '0;
			s.scl_oe_n <= 1'b1;
			s.sda_oe_n <= 1'b1;
		end
		else
		begin
			s <= nxt_s;
		end
	end

	// ==================================================================
	// Outputs
	assign cmd_ready = s.rdy;
	assign busy      = s.busy;
	assign done      = s.done;
	assign nack      = s.nack;
	assign scl_out   = s.pin_lvl;
	assign scl_oe_n  = s.scl_oe_n;
	assign sda_out   = s.pin_lvl;
	assign sda_oe_n  = s.sda_oe_n;

	// ==================================================================
	// Phase run counters for checks
	logic [15:0] lo_run; // Cycles SCL pulled
	logic [15:0] hi_run; // Cycles SCL released

	// Count consecutive cycles at each SCL level
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lo_run <= 16'h0000;
			hi_run <= 16'h0000;
		end
		else if (!s.scl_oe_n)
		begin
			lo_run <= (lo_run == 16'hFFFF) ? lo_run : lo_run + 16'h0001;
			hi_run <= 16'h0000;
		end
		else
		begin
			hi_run <= (hi_run == 16'hFFFF) ? hi_run : hi_run + 16'h0001;
			lo_run <= 16'h0000;
		end
	end

	// ==================================================================
	// Assertions
	property p_idle_start;
		@(posedge clk) disable iff (!resetn)
		$rose(s.busy) |-> $past(s.scl_s) && $past(s.sda_s);
	endproperty
	a_idle_start: assert property (p_idle_start) else $error("start on busy bus");

	property p_sda_stable;
		@(posedge clk) disable iff (!resetn)
		(s.st == stcr_pkg::ST_BHIGH) && ($past(s.st) == stcr_pkg::ST_BHIGH) |-> $stable(s.sda_oe_n);
	endproperty
	a_sda_stable: assert property (p_sda_stable) else $error("SDA moved with SCL high");

	property p_sda_hold;
		@(posedge clk) disable iff (!resetn)
		$fell(s.scl_oe_n) |-> $stable(s.sda_oe_n);
	endproperty
	a_sda_hold: assert property (p_sda_hold) else $error("SDA moved as SCL fell");

	property p_start_edge;
		@(posedge clk) disable iff (!resetn)
		$rose(s.st == stcr_pkg::ST_START) |-> $past(s.sda_oe_n) && !s.sda_oe_n && s.scl_oe_n;
	endproperty
	a_start_edge: assert property (p_start_edge) else $error("bad start condition");

	property p_stop_edge;
		@(posedge clk) disable iff (!resetn)
		$rose(s.st == stcr_pkg::ST_FREE) |-> !$past(s.sda_oe_n) && s.sda_oe_n && $past(s.scl_oe_n);
	endproperty
	a_stop_edge: assert property (p_stop_edge) else $error("bad stop condition");

	property p_ack_release;
		@(posedge clk) disable iff (!resetn)
		(s.st == stcr_pkg::ST_BHIGH) && (s.bit_cnt == `STCR_ACK_BIT) |-> s.sda_oe_n;
	endproperty
	a_ack_release: assert property (p_ack_release) else $error("SDA held in ack");

	property p_low_time;
		@(posedge clk) disable iff (!resetn)
		$rose(s.scl_oe_n) |-> lo_run >= lo_len;
	endproperty
	a_low_time: assert property (p_low_time) else $error("SCL low too short");

	property p_high_time;
		@(posedge clk) disable iff (!resetn)
		$fell(s.scl_oe_n) |-> hi_run >= hi_len;
	endproperty
	a_high_time: assert property (p_high_time) else $error("SCL high too short");

	property p_code_byte;
		@(posedge clk) disable iff (!resetn)
		$rose(s.byte_idx == `STCR_IDX_DATA) |-> s.shreg == {2'h0, s.code};
	endproperty
	a_code_byte: assert property (p_code_byte) else $error("code byte malformed");

	property p_nack_stop;
		@(posedge clk) disable iff (!resetn)
		(s.st == stcr_pkg::ST_BHIGH) && (s.bit_cnt == `STCR_ACK_BIT) && tick && !s.ld
			&& (s.byte_idx == `STCR_IDX_ADDR) && s.sda_s
			|=> (s.st == stcr_pkg::ST_PLOW) && s.nack;
	endproperty
	a_nack_stop: assert property (p_nack_stop) else $error("refused address not stopped");

	c_std_done: cover property (@(posedge clk) disable iff (!resetn) s.done && !s.nack && !s.slow);
	c_slow_done: cover property (@(posedge clk) disable iff (!resetn) s.done && !s.nack && s.slow);
	c_nack: cover property (@(posedge clk) disable iff (!resetn) s.done && s.nack);
	c_rstart: cover property (@(posedge clk) disable iff (!resetn) s.st == stcr_pkg::ST_RSHIGH);

endmodule : stcr_master

// ---- verification/stcr_tone_dev.sv ----
// Purpose: Behavioural tone receiver answering the bus master
// Assumes: Open-drain lines resolved in the bench, pull-ups on both
// Notes:   Ack delay gives a prompt or a late answer
module stcr_tone_dev
(
	// Bus lines
	input  wire logic        scl,
	input  wire logic        sda,
	// Strap and answer timing
	input  wire logic        strap,
	input  wire logic [5:0]  addr_high,
	input  wire logic [11:0] ack_dly,
	// Pin drive and tone
	output logic             sda_oe_n,
	output logic             tone_on,
	output logic [5:0]       tone_code
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==================================================================
	// Receiver state
	int         cnt; // Bits of current byte
	logic [7:0] sh;  // Byte shifter
	logic       sel; // Addressed in this frame
	logic       adr; // Next byte is the address
	logic       frm; // Inside a frame

	// Standby at power-on, silent
	initial
	begin
		sda_oe_n = 1'h1;
		tone_on = 1'h0;
		tone_code = 6'h00;
		frm = 1'h0;
		sel = 1'h0;
	end

	// Start: SDA falls while SCL high
	always @(negedge sda)
		if (scl === 1'h1)
		begin
			frm = 1'h1;
			adr = 1'h1;
			cnt = 0;
		end

	// Stop: drop frame and any partial byte
	always @(posedge sda)
		if (scl === 1'h1)
		begin
			frm = 1'h0;
			sda_oe_n = 1'h1;
		end

	// Sample while SCL high, at any bus speed
	always @(posedge scl)
		if (frm && cnt < 8)
		begin
			sh = {sh[6:0], sda};
			cnt++;
		end

	// Ack drive after a byte, release after the ack clock
	always @(negedge scl)
		if (frm && cnt == 8)
		begin
			if (adr)
				sel = (sh === {addr_high, strap, 1'h0});
			cnt = 9;
			if (sel)
			begin
				#(ack_dly);
				sda_oe_n = 1'h0;
			end
		end
		else if (frm && cnt == 9)
		begin
			sda_oe_n = 1'h1;
			if (sel && !adr)
			begin
				// Code picks the crystal divider of the tone; only the code is kept
				tone_code = sh[5:0];
				tone_on = 1'h1;
			end
			adr = 1'h0;
			cnt = 0;
		end
endmodule : stcr_tone_dev

// ---- verification/serial_tone_code_receiver_tb.sv ----
// Purpose: Self-checking bench of the tone code bus master
// Assumes: Open-drain wires, shortened slow mode phases
// Notes:   Line timing and control edges watched on the wires
module serial_tone_code_receiver_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ==================================================================
	// Settings and signals
	localparam logic [15:0] SLOW_LOW  = 16'h0027; // Slow low length
	localparam logic [15:0] SLOW_HIGH = 16'h0077; // Slow high length
	localparam logic [5:0]  ADDR_HI   = 6'h2A;    // Arbitrary address top
	logic        clk, resetn, cmd_valid, cmd_slow, m_strap, d_strap;
	logic [5:0]  cmd_code, tone_code;
	logic        cmd_ready, busy, done, nack, tone_on;
	logic        m_scl_oe_n, m_sda_oe_n, d_sda_oe_n, tb_sda_oe_n;
	logic        scl_w, sda_w, scl_q, sda_q, m_scl_out, m_sda_out;
	logic [11:0] ack_dly;
	logic [5:0]  exp_q[$];    // Acked codes in order
	int          fails, num_checks, ctl_n, run, lo_min, hi_min;
	logic [5:0]  codes[10] = '{6'h24, 6'h27, 6'h28, 6'h2F, 6'h30,
		6'h3A, 6'h3B, 6'h3F, 6'h04, 6'h07};

	// Wired-AND of all pulls
	assign scl_w = m_scl_oe_n;
	assign sda_w = m_sda_oe_n & d_sda_oe_n & tb_sda_oe_n;

	// ==================================================================
	// Instances
	stcr_master #(.SLOW_LOW_CYC(SLOW_LOW), .SLOW_HIGH_CYC(SLOW_HIGH), .ADDR_HIGH(ADDR_HI))
	u_stcr_master (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_slow(cmd_slow), .address_strap_pin(m_strap), .cmd_ready(cmd_ready),
		.busy(busy), .done(done), .nack(nack), .scl_in(scl_w), .scl_out(m_scl_out),
		.scl_oe_n(m_scl_oe_n), .sda_in(sda_w), .sda_out(m_sda_out), .sda_oe_n(m_sda_oe_n));
	stcr_tone_dev u_stcr_tone_dev (.scl(scl_w), .sda(sda_w), .strap(d_strap),
		.addr_high(ADDR_HI), .ack_dly(ack_dly), .sda_oe_n(d_sda_oe_n),
		.tone_on(tone_on), .tone_code(tone_code));

	// Clock of 20 ns
	initial
	begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	// Wire monitor: control edges and shortest phases
	always @(negedge clk)
	begin
		if (cmd_ready === 1'h1)
		begin
			ctl_n = 0;
			lo_min = 99999;
			hi_min = 99999;
		end
		else if (scl_w && scl_q && sda_w !== sda_q)
			ctl_n++;
		if (scl_w !== scl_q)
		begin
			if (scl_q)
				hi_min = (run < hi_min) ? run : hi_min;
			else
				lo_min = (run < lo_min) ? run : lo_min;
			run = 0;
		end
		run++;
		scl_q = scl_w;
		sda_q = sda_w;
	end

	// ==================================================================
	// Tasks
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	// One command; bad gives the device another strap
	task automatic run_cmd(input logic [5:0] code, input logic slow, input logic bad);
		int n;
		m_strap = 1'($urandom_range(1));
		d_strap = bad ? ~m_strap : m_strap;
		ack_dly = 12'($urandom_range(slow ? 300 : 3000));
		cmd_code = code;
		cmd_slow = slow;
		cmd_valid = 1'h1;
		n = 0;
		while (cmd_ready !== 1'h1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		if (n == 100)
		begin
			fails++;
			final_report();
		end
		@(negedge clk);
		cmd_valid = 1'h0;
		check("busy", busy, 1'h1);
		if (!bad)
			exp_q.push_back(code);
		n = 0;
		while (done !== 1'h1 && n < 20000)
		begin
			@(negedge clk);
			n++;
		end
		if (n == 20000)
		begin
			fails++;
			final_report();
		end
		check("nack", nack, bad);
		check("tone", {tone_on, tone_code}, {1'h1, exp_q[$]});
		check("ctl_edges", 16'(ctl_n), 16'(2 + slow));
		check("pin_level", {m_scl_out, m_sda_out}, 2'h0);
		if (slow)
			check("slow_low", lo_min >= SLOW_LOW, 1'h1);
		else
			check("std_phase", {lo_min >= 235, hi_min >= 200}, 2'h3);
		@(negedge clk);
	endtask : run_cmd

	// ==================================================================
	// Main sequence
	initial
	begin
		void'($urandom(14488));
		resetn = 1'h0;
		cmd_valid = 1'h0;
		cmd_code = 6'h00;
		cmd_slow = 1'h0;
		m_strap = 1'h0;
		d_strap = 1'h0;
		ack_dly = 12'h000;
		tb_sda_oe_n = 1'h1;
		repeat (3) @(negedge clk);
		check("reset", {busy, cmd_ready, m_scl_oe_n, m_sda_oe_n}, 4'h3);
		check("standby", tone_on, 1'h0);
		resetn = 1'h1;
		tb_sda_oe_n = 1'h0;
		cmd_valid = 1'h1;
		repeat (40) @(negedge clk);
		check("busy_bus", {busy, cmd_ready}, 2'h0);
		cmd_valid = 1'h0;
		tb_sda_oe_n = 1'h1;
		for (int i = 0; i < 10; i++)
			run_cmd(codes[i], 1'(i), 1'h0);
		run_cmd(6'h25, 1'h0, 1'h1);
		run_cmd(6'h30 + 6'($urandom_range(15)), 1'h1, 1'h0);
		final_report();
	end
endmodule : serial_tone_code_receiver_tb
